// ==== mpbi_pkg.sv ====
// shared types and constants for the pin bus interface
package mpbi_pkg;
	typedef enum logic [5:0] {
		PH_S1   = 6'h01,
		PH_S2   = 6'h02,
		PH_S3   = 6'h04,
		PH_S4   = 6'h08,
		PH_S5   = 6'h10,
		PH_WAIT = 6'h20
	} mpbi_phase_t;

	typedef enum logic [2:0] {
		K_NONE  = 3'h0,
		K_FETCH = 3'h1,
		K_DRD   = 3'h2,
		K_DWR   = 3'h3,
		K_BRD   = 3'h4,
		K_BWR   = 3'h5,
		K_EXP   = 3'h6
	} mpbi_kind_t;

	localparam logic [11:0] INT_VECTOR  = 12'h003;
	localparam logic [1:0]  EXP_READ_OP = 2'h0;
	localparam logic [1:0]  READ_LAG    = 2'h2;
	localparam int          INT_ROM_BYTES = 1024;

	typedef struct packed {
		mpbi_phase_t phase;
		mpbi_kind_t  kind;
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        extFetch;
		logic        last;
		logic        ale;
		logic        fetchN;
		logic        rdN;
		logic        wrN;
		logic        expander_strobe;
		logic [7:0]  busOut;
		logic        busOe;
		logic [7:0]  busLatch;
		logic        staticMode;
		logic        ovrOn;
		logic [7:0]  ovrOut;
		logic        ovrOe;
		logic [1:0]  readLag;
		logic        readExp;
		logic [7:0]  rdata;
		logic        rdValid;
		logic        start;
		logic        intEn;
		logic        intBusy;
		logic        intTake;
		logic [11:0] intVec;
		logic        intActS1;
		logic        intActS2;
		logic        ssActS1;
		logic        ssActS2;
		logic        eaS1;
		logic        eaS2;
		logic        t0S1;
		logic        t0S2;
		logic        t1S1;
		logic        t1S2;
		logic        t1Prev;
		logic [7:0]  busS1;
		logic [7:0]  busS2;
		logic        cntRun;
		logic [7:0]  cnt;
		logic        ovf;
		logic        clkOutEn;
		logic        t0Out;
		logic        waitSt;
	} mpbi_state_t;

	localparam mpbi_state_t MPBI_RST = '{phase: PH_S5, kind: K_NONE, fetchN: 1'b1,
		rdN: 1'b1, wrN: 1'b1, expander_strobe: 1'b1, default: '0};
endpackage : mpbi_pkg

// ==== mpbi_quasi_port.sv ====
// quasi-bidirectional port with per-line override
`timescale 1ns/10ps
module mpbi_quasi_port #(
	parameter int W = 8
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic         ce,
	input  wire logic         wrEn,
	input  wire logic [W-1:0] wrData,
	input  wire logic [W-1:0] ovrMask,
	input  wire logic [W-1:0] ovrOut,
	input  wire logic         ovrOe,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut,
	output logic      [W-1:0] pinOe,
	output logic      [W-1:0] rdData
);
	typedef struct packed {
		logic [W-1:0] latch;
		logic [W-1:0] pinOut;
		logic [W-1:0] pinOe;
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} mpbi_qport_t;

	mpbi_qport_t r;
	mpbi_qport_t n;
	logic [W-1:0] latchN;
	logic [W-1:0] outN;
	logic [W-1:0] oeN;

	for (genvar i = 0; i < W; i++) begin : g_bit
		logic boost;
		assign latchN[i] = wrEn ? wrData[i] : r.latch[i];
		// short strong pull-up on a 0 to 1 write, else weak pull-up only
		assign boost     = wrEn & wrData[i] & ~r.latch[i];
		assign oeN[i]    = ovrMask[i] ? ovrOe : (~latchN[i] | boost);
		assign outN[i]   = ovrMask[i] ? ovrOut[i] : latchN[i];
	end

	always_comb begin
		n        = r;
		n.latch  = latchN;
		n.pinOut = outN;
		n.pinOe  = oeN;
		n.s1     = pinIn;
		n.s2     = r.s1;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '{latch: '1, pinOut: '1, default: '0};
		end else if (ce) begin
			r <= n;
		end
	end

	assign pinOut = r.pinOut;
	assign pinOe  = r.pinOe;
	assign rdData = r.s2;
endmodule : mpbi_quasi_port

// ==== mpbi_pin_bus.sv ====
// pin-level bus, port, test and interrupt sequencer of the microcomputer
`timescale 1ns/10ps
module mpbi_pin_bus #(
	parameter int ROM_BYTES = mpbi_pkg::INT_ROM_BYTES
) (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic [2:0]  cycleKind,
	input  wire logic [11:0] cycleAddr,
	input  wire logic [7:0]  cycleWdata,
	input  wire logic        instrLast,
	output logic             cycleStart,
	output logic      [7:0]  cycleRdata,
	output logic             cycleRdValid,
	input  wire logic        port1Wr,
	input  wire logic [7:0]  port1Wdata,
	output logic      [7:0]  port1Rdata,
	input  wire logic        port2Wr,
	input  wire logic [7:0]  port2Wdata,
	output logic      [7:0]  port2Rdata,
	input  wire logic [7:0]  port1In,
	output logic      [7:0]  port1Out,
	output logic      [7:0]  port1Oe,
	input  wire logic [7:0]  port2In,
	output logic      [7:0]  port2Out,
	output logic      [7:0]  port2Oe,
	input  wire logic [7:0]  busIn,
	output logic      [7:0]  busOut,
	output logic             busOe,
	output logic             addrLatchStrobe,
	output logic             programFetchStrobeN,
	output logic             readStrobeN,
	output logic             writeStrobeN,
	output logic             expanderStrobe,
	input  wire logic        externalFetchSelect,
	input  wire logic        testPinZeroIn,
	output logic             testPinZeroOut,
	output logic             testPinZeroOe,
	input  wire logic        testPinOneIn,
	input  wire logic        clockOutEnableInstr,
	input  wire logic        startEventCountInstr,
	input  wire logic        stopCountInstr,
	input  wire logic        overflowClr,
	output logic             testZeroLevel,
	output logic             testOneLevel,
	output logic      [7:0]  eventCount,
	output logic             countOverflow,
	input  wire logic        intReqN,
	input  wire logic        intEnableSet,
	input  wire logic        intEnableClr,
	input  wire logic        intReturn,
	output logic             intTake,
	output logic      [11:0] intVector,
	output logic             intLevelActive,
	input  wire logic        singleStepN,
	output logic             waitState
);
	mpbi_pkg::mpbi_state_t r;
	mpbi_pkg::mpbi_state_t n;
	logic [7:0] p2Rd;

	always_comb begin
		logic inc;
		logic isExtF;
		logic isData;
		logic isW;
		logic isR;
		logic isExp;
		logic expRd;
		logic addrPh;
		logic strPh;
		logic datPh;
		inc    = 1'b0;
		isExtF = 1'b0;
		isData = 1'b0;
		isW    = 1'b0;
		isR    = 1'b0;
		isExp  = 1'b0;
		expRd  = 1'b0;
		addrPh = 1'b0;
		strPh  = 1'b0;
		datPh  = 1'b0;
		n         = r;
		n.start   = 1'b0;
		n.rdValid = 1'b0;
		n.intTake = 1'b0;
		n.intActS1 = ~intReqN;
		n.intActS2 = r.intActS1;
		n.ssActS1  = ~singleStepN;
		n.ssActS2  = r.ssActS1;
		n.eaS1     = externalFetchSelect;
		n.eaS2     = r.eaS1;
		n.t0S1     = testPinZeroIn;
		n.t0S2     = r.t0S1;
		n.t1S1     = testPinOneIn;
		n.t1S2     = r.t1S1;
		n.busS1    = busIn;
		n.busS2    = r.busS1;
		n.t1Prev   = r.t1S2;
		// event counter on falling edges of test one
		if (startEventCountInstr) begin
			n.cntRun = 1'b1;
		end
		if (stopCountInstr) begin
			n.cntRun = 1'b0;
		end
		inc = r.cntRun & r.t1Prev & ~r.t1S2;
		if (inc) begin
			n.cnt = r.cnt + 8'h01;
		end
		if (overflowClr) begin
			n.ovf = 1'b0;
		end
		if (inc && r.cnt == 8'hFF) begin
			n.ovf = 1'b1;
		end
		// clock output on test zero
		if (clockOutEnableInstr) begin
			n.clkOutEn = 1'b1;
		end
		n.t0Out = n.clkOutEn ? ~r.t0Out : 1'b0;
		if (intEnableSet) begin
			n.intEn = 1'b1;
		end
		if (intEnableClr) begin
			n.intEn = 1'b0;
		end
		if (intReturn) begin
			n.intBusy = 1'b0;
		end
		// read data returns once the synchronised pins show the strobe window
		if (r.readLag != 2'h0) begin
			n.readLag = r.readLag - 2'h1;
			if (r.readLag == 2'h1) begin
				n.rdValid = 1'b1;
				n.rdata   = r.readExp ? {4'h0, p2Rd[3:0]} : r.busS2;
			end
		end
		case (r.phase)
			mpbi_pkg::PH_S1: begin
				n.phase = mpbi_pkg::PH_S2;
				if (r.intActS2 && r.intEn && !r.intBusy) begin
					n.intTake = 1'b1;
					n.intBusy = 1'b1;
					n.intVec  = mpbi_pkg::INT_VECTOR;
				end
			end
			mpbi_pkg::PH_S2: n.phase = mpbi_pkg::PH_S3;
			mpbi_pkg::PH_S3: n.phase = mpbi_pkg::PH_S4;
			mpbi_pkg::PH_S4: n.phase = mpbi_pkg::PH_S5;
			mpbi_pkg::PH_S5: begin
				if ((r.kind == mpbi_pkg::K_FETCH && r.extFetch) || r.kind == mpbi_pkg::K_DRD ||
					r.kind == mpbi_pkg::K_BRD ||
					(r.kind == mpbi_pkg::K_EXP && r.wdata[7:6] == mpbi_pkg::EXP_READ_OP)) begin
					n.readLag = mpbi_pkg::READ_LAG;
					n.readExp = (r.kind == mpbi_pkg::K_EXP);
				end
				// instruction boundary given by the core's last-cycle flag
				n.phase = (r.last && r.ssActS2) ? mpbi_pkg::PH_WAIT : mpbi_pkg::PH_S1;
			end
			mpbi_pkg::PH_WAIT: n.phase = r.ssActS2 ? mpbi_pkg::PH_WAIT : mpbi_pkg::PH_S1;
			default: n.phase = mpbi_pkg::PH_S1;
		endcase
		n.waitSt = (n.phase == mpbi_pkg::PH_WAIT);
		if (n.phase == mpbi_pkg::PH_S1 && r.phase != mpbi_pkg::PH_S1) begin
			n.kind     = mpbi_pkg::mpbi_kind_t'(cycleKind);
			n.addr     = cycleAddr;
			n.wdata    = cycleWdata;
			n.last     = instrLast;
			n.extFetch = r.eaS2 || ({20'h0, cycleAddr} >= ROM_BYTES);
			n.start    = 1'b1;
			if (cycleKind == mpbi_pkg::K_BWR) begin
				n.busLatch   = cycleWdata;
				n.staticMode = 1'b1;
			end
			if (cycleKind == mpbi_pkg::K_BRD) begin
				n.staticMode = 1'b0;
			end
		end
		// pin outputs for the phase being entered
		isExtF = (n.kind == mpbi_pkg::K_FETCH) && n.extFetch;
		isData = (n.kind == mpbi_pkg::K_DRD) || (n.kind == mpbi_pkg::K_DWR);
		isW    = (n.kind == mpbi_pkg::K_DWR) || (n.kind == mpbi_pkg::K_BWR);
		isR    = (n.kind == mpbi_pkg::K_DRD) || (n.kind == mpbi_pkg::K_BRD);
		isExp  = (n.kind == mpbi_pkg::K_EXP) && !n.waitSt;
		expRd  = (n.wdata[7:6] == mpbi_pkg::EXP_READ_OP);
		addrPh = (n.phase == mpbi_pkg::PH_S1) || (n.phase == mpbi_pkg::PH_S2);
		strPh  = (n.phase == mpbi_pkg::PH_S4) || (n.phase == mpbi_pkg::PH_S5);
		datPh  = strPh || (n.phase == mpbi_pkg::PH_S3);
		n.ale    = (n.phase == mpbi_pkg::PH_S1);
		n.fetchN = ~(isExtF && strPh);
		n.rdN    = ~(isR && strPh);
		n.wrN    = ~(isW && strPh);
		n.expander_strobe   = ~(isExp && datPh);
		if ((isExtF || isData) && addrPh) begin
			n.busOe  = 1'b1;
			n.busOut = n.addr[7:0];
		end else if (isW && datPh) begin
			n.busOe  = 1'b1;
			n.busOut = n.wdata;
		end else if ((isExtF || isR) && datPh) begin
			n.busOe  = 1'b0;
			n.busOut = 8'h00;
		end else begin
			n.busOe  = n.staticMode;
			n.busOut = n.staticMode ? n.busLatch : 8'h00;
		end
		n.ovrOn = (isExtF && !n.waitSt) || isExp;
		if (isExtF) begin
			n.ovrOut = {4'h0, n.addr[11:8]};
			n.ovrOe  = 1'b1;
		end else if (n.phase == mpbi_pkg::PH_S4 || n.phase == mpbi_pkg::PH_S5) begin
			n.ovrOut = {4'h0, n.wdata[3:0]};
			n.ovrOe  = ~expRd;
		end else begin
			n.ovrOut = {4'h0, n.wdata[7:4]};
			n.ovrOe  = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= mpbi_pkg::MPBI_RST;
		end else if (ce) begin
			r <= n;
		end
	end

	mpbi_quasi_port #(
		.W(8)
	) u_port1 (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.ce       (ce),
		.wrEn     (port1Wr),
		.wrData   (port1Wdata),
		.ovrMask  (8'h00),
		.ovrOut   (8'h00),
		.ovrOe    (1'b0),
		.pinIn    (port1In),
		.pinOut   (port1Out),
		.pinOe    (port1Oe),
		.rdData   (port1Rdata)
	);

	mpbi_quasi_port #(
		.W(8)
	) u_port2 (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.ce       (ce),
		.wrEn     (port2Wr),
		.wrData   (port2Wdata),
		.ovrMask  ({4'h0, {4{r.ovrOn}}}),
		.ovrOut   (r.ovrOut),
		.ovrOe    (r.ovrOe),
		.pinIn    (port2In),
		.pinOut   (port2Out),
		.pinOe    (port2Oe),
		.rdData   (p2Rd)
	);

	assign port2Rdata          = p2Rd;
	assign cycleStart          = r.start;
	assign cycleRdata          = r.rdata;
	assign cycleRdValid        = r.rdValid;
	assign busOut              = r.busOut;
	assign busOe               = r.busOe;
	assign addrLatchStrobe     = r.ale;
	assign programFetchStrobeN = r.fetchN;
	assign readStrobeN         = r.rdN;
	assign writeStrobeN        = r.wrN;
	assign expanderStrobe      = r.expander_strobe;
	assign testPinZeroOut      = r.t0Out;
	assign testPinZeroOe       = r.clkOutEn;
	assign testZeroLevel       = r.t0S2;
	assign testOneLevel        = r.t1S2;
	assign eventCount          = r.cnt;
	assign countOverflow       = r.ovf;
	assign intTake             = r.intTake;
	assign intVector           = r.intVec;
	assign intLevelActive      = r.intActS2;
	assign waitState           = r.waitSt;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b || !ce);

	property p_ale_pulse;
		addrLatchStrobe |=> !addrLatchStrobe [*4];
	endproperty
	a_ale_pulse: assert property (p_ale_pulse) else $error("latch pulse too long");

	property p_ale_every;
		addrLatchStrobe |-> ##5 (addrLatchStrobe || waitState);
	endproperty
	a_ale_every: assert property (p_ale_every) else $error("latch pulse missing");

	property p_fetch_ext;
		!programFetchStrobeN |-> (r.kind == mpbi_pkg::K_FETCH) && r.extFetch;
	endproperty
	a_fetch_ext: assert property (p_fetch_ext) else $error("fetch strobe not external");

	property p_fetch_release;
		$fell(programFetchStrobeN) |-> !$past(busOe);
	endproperty
	a_fetch_release: assert property (p_fetch_release) else $error("bus driven at fetch");

	property p_addr_first;
		$fell(programFetchStrobeN) |-> $past(addrLatchStrobe, 3);
	endproperty
	a_addr_first: assert property (p_addr_first) else $error("no address before fetch");

	property p_rd_pulse;
		$fell(readStrobeN) |=> !readStrobeN ##1 readStrobeN;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe width");

	property p_wr_data;
		!writeStrobeN |-> busOe && (busOut == r.wdata);
	endproperty
	a_wr_data: assert property (p_wr_data) else $error("write without data");

	property p_int_take;
		intTake |-> $past(addrLatchStrobe) && $past(r.intEn) && intVector == 12'h003;
	endproperty
	a_int_take: assert property (p_int_take) else $error("bad interrupt take");

	property p_expander_strobe_exp;
		!expanderStrobe |-> r.kind == mpbi_pkg::K_EXP;
	endproperty
	a_expander_strobe_exp: assert property (p_expander_strobe_exp) else $error("stray expander strobe");

	property p_cnt_inc;
		(r.cntRun && r.t1Prev && !r.t1S2) |=> eventCount == $past(eventCount) + 8'h01;
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("event not counted");

	property p_wait_hold;
		waitState && r.ssActS2 |=> !addrLatchStrobe;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("cycle during wait");

	property p_cv_fetch;
		$fell(programFetchStrobeN);
	endproperty
	c_cv_fetch: cover property (p_cv_fetch);

	property p_cv_int;
		intTake;
	endproperty
	c_cv_int: cover property (p_cv_int);

	property p_cv_wait;
		$rose(waitState) ##[1:20] $fell(waitState);
	endproperty
	c_cv_wait: cover property (p_cv_wait);

	property p_cv_exp;
		$fell(expanderStrobe) ##3 expanderStrobe;
	endproperty
	c_cv_exp: cover property (p_cv_exp);
endmodule : mpbi_pin_bus

// ==== mpbi_ext_mem.sv ====
// behavioural external program/data memory and expander
`timescale 1ns/10ps
module mpbi_ext_mem (
	input  wire logic       core_clk,
	input  wire logic       addrLatchStrobe,
	input  wire logic       programFetchStrobeN,
	input  wire logic       readStrobeN,
	input  wire logic       writeStrobeN,
	input  wire logic       expanderStrobe,
	input  wire logic [7:0] busOut,
	input  wire logic       busOe,
	input  wire logic [3:0] port2Pin,
	output logic      [7:0] busIn,
	output logic            expDrive,
	output logic      [3:0] expVal
);
	logic [7:0]  pmem [0:4095];
	logic [7:0]  dmem [0:255];
	logic [3:0]  xreg [0:3];
	logic [7:0]  lowA;
	logic [7:0]  last;
	logic [11:0] fetchA;
	logic [3:0]  cmd;

	initial begin
		for (int i = 0; i < 4096; i++) begin
			pmem[i] = i[7:0] ^ {i[11:8], 4'h6};
			dmem[i[7:0]] = i[7:0] ^ 8'h5A;
			xreg[i[1:0]] = 4'h0;
		end
		lowA = 8'h00;
		last = 8'h00;
		fetchA = 12'h000;
		cmd = 4'h0;
	end

	// low address taken as the latch strobe falls
	always @(negedge addrLatchStrobe)
		lowA <= busOe ? busOut : busIn;

	always @(negedge core_clk) begin
		if (programFetchStrobeN)
			fetchA <= {port2Pin, lowA};
		if (!writeStrobeN)
			dmem[lowA] <= busOut;
		if (expanderStrobe)
			cmd <= port2Pin;
		else if (cmd[3:2] != 2'h0)
			xreg[cmd[1:0]] <= port2Pin;
	end

	always @(posedge core_clk)
		last <= busIn;

	// released bus shows a changing pattern, not the last value
	always_comb begin
		if (!programFetchStrobeN)
			busIn = pmem[fetchA];
		else if (!readStrobeN)
			busIn = dmem[lowA];
		else if (busOe)
			busIn = busOut;
		else
			busIn = ~last;
	end

	assign expDrive = !expanderStrobe && cmd[3:2] == 2'h0;
	assign expVal = xreg[cmd[1:0]];
endmodule : mpbi_ext_mem

// ==== mpbi_pin_bus_test.sv ====
// self-checking bench for the pin bus interface
`timescale 1ns/10ps
module mpbi_pin_bus_test;
	logic        core_clk, rst_b, ce, instrLast, cycleStart, cycleRdValid, port1Wr, port2Wr;
	logic        busOe, addrLatchStrobe, programFetchStrobeN, readStrobeN, writeStrobeN;
	logic        expanderStrobe, externalFetchSelect, testPinZeroIn, testPinZeroOut;
	logic        testPinZeroOe, testPinOneIn, clockOutEnableInstr, startEventCountInstr;
	logic        stopCountInstr, overflowClr, testZeroLevel, testOneLevel, countOverflow;
	logic        intReqN, intEnableSet, intEnableClr, intReturn, intTake, intLevelActive;
	logic        singleStepN, waitState, expDrive;
	logic [2:0]  cycleKind;
	logic [3:0]  expVal;
	logic [7:0]  cycleWdata, cycleRdata, port1Wdata, port1Rdata, port2Wdata, port2Rdata;
	logic [7:0]  port1Out, port1Oe, port2Out, port2Oe, busIn, busOut, eventCount, p1Ext, rd;
	logic [11:0] cycleAddr, intVector;
	wire  [7:0]  port1In, port2In;
	int          failures, checked, got;
	int          seen [6];

	mpbi_pin_bus u_mpbi_pin_bus (
		.core_clk, .rst_b, .ce, .cycleKind, .cycleAddr, .cycleWdata, .instrLast, .cycleStart,
		.cycleRdata, .cycleRdValid, .port1Wr, .port1Wdata, .port1Rdata, .port2Wr, .port2Wdata,
		.port2Rdata, .port1In, .port1Out, .port1Oe, .port2In, .port2Out, .port2Oe, .busIn,
		.busOut, .busOe, .addrLatchStrobe, .programFetchStrobeN, .readStrobeN, .writeStrobeN,
		.expanderStrobe, .externalFetchSelect, .testPinZeroIn, .testPinZeroOut, .testPinZeroOe,
		.testPinOneIn, .clockOutEnableInstr, .startEventCountInstr, .stopCountInstr,
		.overflowClr, .testZeroLevel, .testOneLevel, .eventCount, .countOverflow, .intReqN,
		.intEnableSet, .intEnableClr, .intReturn, .intTake, .intVector, .intLevelActive,
		.singleStepN, .waitState
	);
	mpbi_ext_mem u_mpbi_ext_mem (
		.core_clk, .addrLatchStrobe, .programFetchStrobeN, .readStrobeN, .writeStrobeN,
		.expanderStrobe, .busOut, .busOe, .port2Pin(port2In[3:0]), .busIn, .expDrive, .expVal
	);

	// undriven port one lines follow p1Ext; port two lines read high unless the expander drives
	assign port1In = (port1Oe & port1Out) | (~port1Oe & p1Ext);
	assign port2In = (port2Oe & port2Out) | (~port2Oe & {4'hF, expDrive ? expVal : 4'hF});

	always #50 core_clk = ~core_clk;

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	function automatic logic sig(input int k);
		case (k)
			0: return intTake;
			1: return cycleStart;
			default: return testPinZeroOut;
		endcase
	endfunction : sig

	task automatic watch(input int k, input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge core_clk);
			#1;
			c += (sig(k) === 1'b1);
		end
	endtask : watch

	task automatic pulse(input int k);
		@(posedge core_clk);
		case (k)
			0: intEnableSet <= 1'b1;
			1: intReturn <= 1'b1;
			2: clockOutEnableInstr <= 1'b1;
			3: startEventCountInstr <= 1'b1;
			4: overflowClr <= 1'b1;
			5: intEnableClr <= 1'b1;
			default: stopCountInstr <= 1'b1;
		endcase
		@(posedge core_clk);
		{intEnableSet, intReturn, clockOutEnableInstr, startEventCountInstr, overflowClr,
			intEnableClr, stopCountInstr} <= '0;
	endtask : pulse

	// one machine cycle; counts strobe cycles over c0..c4, takes read data up to c7
	task automatic run(input logic [2:0] k, input logic [11:0] a, input logic [7:0] d,
			input logic l);
		int t;
		@(posedge core_clk);
		cycleKind <= k;
		cycleAddr <= a;
		cycleWdata <= d;
		instrLast <= l;
		t = 0;
		do begin
			@(posedge core_clk);
			#1;
			t++;
		end while (cycleStart !== 1'b1 && t < 30);
		if (cycleStart !== 1'b1) begin
			failures++;
			print_verdict();
		end
		seen = '{default: 0};
		got = 0;
		rd = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (i < 5) begin
				seen[0] += addrLatchStrobe;
				seen[1] += !programFetchStrobeN;
				seen[2] += !readStrobeN;
				seen[3] += !writeStrobeN;
				seen[4] += !expanderStrobe;
				seen[5] += busOe & !(programFetchStrobeN & readStrobeN);
			end
			if (cycleRdValid === 1'b1) begin
				got++;
				rd = cycleRdata;
			end
			@(posedge core_clk);
			if (i == 0)
				cycleKind <= 3'h0;
			#1;
		end
	endtask : run

	task automatic t_reset;
		repeat (2) @(posedge core_clk);
		#1;
		chk("idle strobes", 12'h00F, {8'h00, programFetchStrobeN, readStrobeN, writeStrobeN,
			expanderStrobe});
		chk("reset outputs", 12'h000, {busOe, port1Oe, testPinZeroOe, waitState, intTake});
		@(posedge core_clk);
		rst_b <= 1'b1;
	endtask : t_reset

	task automatic t_fetch(input logic [11:0] a, input logic sel, input logic ext);
		@(posedge core_clk);
		externalFetchSelect <= sel;
		repeat (3) @(posedge core_clk);
		run(3'h1, a, 8'h00, 1'b0);
		chk("latch pulses", 12'h001, seen[0][11:0]);
		chk("fetch strobe cycles", ext ? 12'h002 : 12'h000, seen[1][11:0]);
		chk("fetch valid", {11'h000, ext}, got[11:0]);
		chk("bus contention", 12'h000, seen[5][11:0]);
		if (ext)
			chk("fetch data", {4'h0, a[7:0] ^ {a[11:8], 4'h6}}, {4'h0, rd});
	endtask : t_fetch

	task automatic t_data;
		run(3'h3, 12'h047, 8'h3C, 1'b0);
		chk("write strobe cycles", 12'h002, seen[3][11:0]);
		chk("bus after write", 12'h000, {11'h000, busOe});
		run(3'h2, 12'h047, 8'h00, 1'b1);
		chk("read strobe cycles", 12'h002, seen[2][11:0]);
		chk("read data", 12'h03C, {4'h0, rd});
		chk("read contention", 12'h000, seen[5][11:0]);
	endtask : t_data

	task automatic t_static;
		run(3'h5, 12'h000, 8'h96, 1'b0);
		repeat (5) @(posedge core_clk);
		#1;
		chk("static bus value", 12'h196, {3'h0, busOe, busOut});
		run(3'h4, 12'h000, 8'h00, 1'b0);
		chk("static read", 12'h021, {seen[2][7:0], got[3:0]});
		chk("bus released", 12'h000, {11'h000, busOe});
	endtask : t_static

	task automatic t_exp;
		run(3'h6, 12'h000, 8'h6C, 1'b0);
		chk("expander strobe cycles", 12'h003, seen[4][11:0]);
		run(3'h6, 12'h000, 8'h20, 1'b0);
		chk("expander read", 12'h10C, {3'h0, got[0], 4'h0, rd[3:0]});
	endtask : t_exp

	task automatic t_port(input logic [7:0] w, input logic [7:0] ext, input logic [7:0] e);
		@(posedge core_clk);
		port1Wr <= 1'b1;
		port1Wdata <= w;
		p1Ext <= ext;
		@(posedge core_clk);
		port1Wr <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		chk("port drive", {4'h0, ~w}, {4'h0, port1Oe});
		chk("port pins", {4'h0, e}, {4'h0, port1Rdata});
		chk("port two pins", 12'h0FF, {4'h0, port2Rdata});
	endtask : t_port

	task automatic t_int;
		int c;
		@(posedge core_clk);
		intReqN <= 1'b0;
		watch(0, 15, c);
		chk("take while disabled", 12'h000, c[11:0]);
		chk("interrupt level", 12'h001, {11'h000, intLevelActive});
		pulse(0);
		watch(0, 15, c);
		chk("single take", 12'h001, c[11:0]);
		chk("vector", 12'h003, intVector);
		@(posedge core_clk);
		intReqN <= 1'b1;
		pulse(1);
		pulse(5);
		intReqN <= 1'b0;
		watch(0, 15, c);
		chk("take after disable", 12'h000, c[11:0]);
		@(posedge core_clk);
		intReqN <= 1'b1;
	endtask : t_int

	task automatic t_test;
		int c;
		@(posedge core_clk);
		testPinZeroIn <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		chk("test zero level", 12'h000, {11'h000, testZeroLevel});
		pulse(2);
		watch(2, 10, c);
		chk("clock out highs", 12'h005, c[11:0]);
		chk("clock out drive", 12'h001, {11'h000, testPinZeroOe});
		pulse(3);
		// events spaced three machine cycles apart
		for (int i = 0; i < 257; i++) begin
			@(posedge core_clk);
			testPinOneIn <= 1'b0;
			repeat (8) @(posedge core_clk);
			testPinOneIn <= 1'b1;
			repeat (6) @(posedge core_clk);
		end
		#1;
		chk("event count", 12'h101, {3'h0, countOverflow, eventCount});
		chk("test one level", 12'h001, {11'h000, testOneLevel});
		pulse(6);
		@(posedge core_clk);
		testPinOneIn <= 1'b0;
		repeat (8) @(posedge core_clk);
		testPinOneIn <= 1'b1;
		pulse(4);
		repeat (2) @(posedge core_clk);
		#1;
		chk("count held", 12'h001, {3'h0, countOverflow, eventCount});
	endtask : t_test

	task automatic t_step;
		int c;
		@(posedge core_clk);
		instrLast <= 1'b0;
		repeat (6) @(posedge core_clk);
		singleStepN <= 1'b0;
		repeat (3) @(posedge core_clk);
		run(3'h0, 12'h000, 8'h00, 1'b1);
		watch(1, 10, c);
		chk("starts in wait", 12'h000, c[11:0]);
		chk("wait flag", 12'h001, {11'h000, waitState});
		@(posedge core_clk);
		singleStepN <= 1'b1;
		watch(1, 6, c);
		chk("start after step", 12'h001, c[11:0]);
	endtask : t_step

	initial begin
		core_clk = 1'b0;
		{rst_b, instrLast, port1Wr, port2Wr, externalFetchSelect, stopCountInstr} = '0;
		{clockOutEnableInstr, startEventCountInstr, overflowClr} = '0;
		{intEnableSet, intEnableClr, intReturn} = '0;
		{ce, intReqN, singleStepN, testPinZeroIn, testPinOneIn} = '1;
		{cycleKind, cycleAddr, cycleWdata, port1Wdata, port2Wdata} = '0;
		p1Ext = 8'hFF;
		failures = 0;
		checked = 0;
		t_reset();
		t_fetch(12'hA53, 1'b0, 1'b1);
		t_fetch(12'h3FF, 1'b0, 1'b0);
		t_fetch(12'h400, 1'b0, 1'b1);
		t_fetch(12'h123, 1'b1, 1'b1);
		t_data();
		t_static();
		t_exp();
		t_port(8'h5A, 8'hFF, 8'h5A);
		t_port(8'hFF, 8'h33, 8'h33);
		t_int();
		t_test();
		t_step();
		print_verdict();
	end
endmodule : mpbi_pin_bus_test
